/* File: src/power_mode_controller.sv */
// Global power mode controller with wakeup, tick counter and boost control
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_cfg.svh"
module power_mode_controller #(
   parameter int HIB_RESUME_CYC = `HIB_RESUME_CYC,
   parameter int TICK_DIV_CYC   = `TICK_DIV_CYC
) (
   input  wire logic                 clock_in,
   input  wire logic                 resetn_in,
   input  wire logic [7:0]           addr_in,
   input  wire logic [31:0]          wdata_in,
   input  wire logic                 wr_in,
   input  wire logic                 rd_in,
   output logic      [31:0]          rdata_out,
   input  wire logic                 cpu_off_req_in,
   input  wire logic                 irq_internal_in,
   input  wire logic                 low_voltage_detect_in,
   input  wire logic                 port_interrupt_unit_in,
   input  wire logic                 watchdog_reset_event_in,
   input  wire logic                 external_reset_pin_n_in,
   input  wire logic                 khz_crystal_osc_in,
   input  wire logic                 boost_below_level_in,
   output logic      [`SUBSYS_W-1:0] subsys_clk_en_out,
   output logic                      cpu_en_out,
   output logic      [1:0]           global_mode_out,
   output logic                      low_speed_clk_sel_out,
   output logic                      retain_out,
   output logic                      resuming_out,
   output logic                      tick_irq_out,
   output logic                      boost_switch_out,
   output logic                      boost_active_out,
   output logic                      boost_standby_out
);
   localparam logic [15:0] SLEEP_CYC = 16'(`SLEEP_RESUME_CYC);
   localparam logic [15:0] HIB_CYC   = 16'(HIB_RESUME_CYC);
   localparam logic [17:0] TICK_DIV  = 18'(TICK_DIV_CYC);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [2:0] pin_raw;
   logic [2:0] sy1_r;
   logic [2:0] sy2_r;
   logic [2:0] sy3_r;
   logic [2:0] lvl_r;
   logic [2:0] lvl_nxt;
   logic       xtal_edge_r;
   logic       xtal_edge_nxt;

   assign pin_raw = {boost_below_level_in, khz_crystal_osc_in, external_reset_pin_n_in};

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         lvl_nxt[i] = (sy2_r[i] == sy3_r[i]) ? sy3_r[i] : lvl_r[i];
      end
      // Both crystal edges count for the boost pulses
      xtal_edge_nxt = lvl_nxt[1] ^ lvl_r[1];
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sy1_r       <= `PIN_LVL_RST;
         sy2_r       <= `PIN_LVL_RST;
         sy3_r       <= `PIN_LVL_RST;
         lvl_r       <= `PIN_LVL_RST;
         xtal_edge_r <= 1'b0;
      end else begin
         sy1_r       <= pin_raw;
         sy2_r       <= sy1_r;
         sy3_r       <= sy2_r;
         lvl_r       <= lvl_nxt;
         xtal_edge_r <= xtal_edge_nxt;
      end
   end

   // ----------------------------------------
   // Register file and mode sequencer
   // ----------------------------------------
   pmc_pkg::pm_state_t   st_r;
   pmc_pkg::pm_state_t   st_nxt;
   logic [`SUBSYS_W-1:0] act_tmpl_r;
   logic [`SUBSYS_W-1:0] act_tmpl_nxt;
   logic [`SUBSYS_W-1:0] alt_tmpl_r;
   logic [`SUBSYS_W-1:0] alt_tmpl_nxt;
   logic [3:0]           wake_en_r;
   logic [3:0]           wake_en_nxt;
   logic [12:0]          tick_per_r;
   logic [12:0]          tick_per_nxt;
   logic                 tick_run_r;
   logic                 tick_run_nxt;
   logic [4:0]           boost_r;
   logic [4:0]           boost_nxt;
   logic                 cpu_on_r;
   logic                 cpu_on_nxt;
   logic [15:0]          rcnt_r;
   logic [15:0]          rcnt_nxt;
   logic [5:0]           cause_r;
   logic [5:0]           cause_nxt;
   logic [3:0]           irq_src;
   logic                 wdr_wake;
   logic                 external_reset_pin_low;
   logic                 wake_any;
   logic                 tick_clr;
   logic                 tick_evt_r;

   always_comb begin
      irq_src = {port_interrupt_unit_in, tick_evt_r, low_voltage_detect_in, irq_internal_in}
                & wake_en_r;
      wdr_wake = watchdog_reset_event_in;
      external_reset_pin_low = ~lvl_r[0];
      wake_any = (|irq_src) | wdr_wake | external_reset_pin_low;
      st_nxt       = st_r;
      act_tmpl_nxt = act_tmpl_r;
      alt_tmpl_nxt = alt_tmpl_r;
      wake_en_nxt  = wake_en_r;
      tick_per_nxt = tick_per_r;
      tick_run_nxt = tick_run_r;
      boost_nxt    = boost_r;
      cpu_on_nxt   = cpu_on_r;
      rcnt_nxt     = rcnt_r;
      cause_nxt    = cause_r;
      tick_clr     = 1'b0;
      // Configuration writes are honoured in every mode and survive hibernate
      if (wr_in) begin
         unique case (addr_in)
            `REG_ACT_TMPL: begin
               act_tmpl_nxt = wdata_in[`SUBSYS_W-1:0];
               cpu_on_nxt   = wdata_in[`CPU_BIT];
            end
            `REG_ALT_TMPL: alt_tmpl_nxt = wdata_in[`SUBSYS_W-1:0];
            `REG_WAKE_EN:  wake_en_nxt = wdata_in[3:0];
            `REG_TICK: begin
               tick_per_nxt = wdata_in[12:0];
               tick_run_nxt = wdata_in[`TICK_RUN_BIT];
               tick_clr     = wdata_in[`TICK_CLR_BIT];
            end
            `REG_BOOST: boost_nxt = wdata_in[4:0];
            default: ;
         endcase
      end
      if (cpu_off_req_in) begin
         cpu_on_nxt = 1'b0;
      end
      unique case (st_r)
         pmc_pkg::ST_ACTIVE, pmc_pkg::ST_ALT: begin
            if (wake_any) begin
               st_nxt     = pmc_pkg::ST_ACTIVE;
               cpu_on_nxt = 1'b1;
               cause_nxt  = {external_reset_pin_low, wdr_wake, irq_src};
            end else if (wr_in && addr_in == `REG_MODE) begin
               unique case (wdata_in[1:0])
                  `MODE_ACTIVE: st_nxt = pmc_pkg::ST_ACTIVE;
                  `MODE_ALT:    st_nxt = pmc_pkg::ST_ALT;
                  `MODE_SLEEP:  st_nxt = pmc_pkg::ST_SLEEP;
                  `MODE_HIB:    st_nxt = pmc_pkg::ST_HIB;
               endcase
            end
         end
         pmc_pkg::ST_SLEEP: begin
            if (external_reset_pin_low) begin
               st_nxt     = pmc_pkg::ST_ACTIVE;
               cpu_on_nxt = 1'b1;
               cause_nxt  = {external_reset_pin_low, wdr_wake, irq_src};
            end else if (wake_any) begin
               st_nxt    = pmc_pkg::ST_RESUME;
               rcnt_nxt  = SLEEP_CYC - 16'h0001;
               cause_nxt = {external_reset_pin_low, wdr_wake, irq_src};
            end
         end
         pmc_pkg::ST_HIB: begin
            if (external_reset_pin_low) begin
               st_nxt     = pmc_pkg::ST_ACTIVE;
               cpu_on_nxt = 1'b1;
               cause_nxt  = {external_reset_pin_low, wdr_wake, irq_src};
            end else if (irq_src[`WAKE_PORT_BIT]) begin
               st_nxt    = pmc_pkg::ST_RESUME;
               rcnt_nxt  = HIB_CYC - 16'h0001;
               cause_nxt = {2'b00, irq_src & 4'h8};
            end
         end
         pmc_pkg::ST_RESUME: begin
            // Regulators settle before any subsystem is switched on again; a low reset pin ends the wait at once
            if (rcnt_r == 16'h0000 || external_reset_pin_low) begin
               st_nxt     = pmc_pkg::ST_ACTIVE;
               cpu_on_nxt = 1'b1;
            end else begin
               rcnt_nxt = rcnt_r - 16'h0001;
            end
         end
         default: st_nxt = pmc_pkg::ST_ACTIVE;
      endcase
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_r       <= pmc_pkg::ST_ACTIVE;
         act_tmpl_r <= `ACT_TMPL_RST;
         alt_tmpl_r <= `ALT_TMPL_RST;
         wake_en_r  <= `WAKE_EN_RST;
         tick_per_r <= `TICK_PER_RST;
         tick_run_r <= 1'b0;
         boost_r    <= `BOOST_RST;
         cpu_on_r   <= 1'b1;
         rcnt_r     <= 16'h0000;
         cause_r    <= 6'h00;
      end else begin
         st_r       <= st_nxt;
         act_tmpl_r <= act_tmpl_nxt;
         alt_tmpl_r <= alt_tmpl_nxt;
         wake_en_r  <= wake_en_nxt;
         tick_per_r <= tick_per_nxt;
         tick_run_r <= tick_run_nxt;
         boost_r    <= boost_nxt;
         cpu_on_r   <= cpu_on_nxt;
         rcnt_r     <= rcnt_nxt;
         cause_r    <= cause_nxt;
      end
   end

   // ----------------------------------------
   // Central tick counter
   // ----------------------------------------
   logic [17:0] tdiv_r;
   logic [17:0] tdiv_nxt;
   logic [12:0] tcnt_r;
   logic [12:0] tcnt_nxt;
   logic        tick_evt_nxt;
   logic        ms_tick;

   always_comb begin
      ms_tick      = (tdiv_r == TICK_DIV - 18'h00001);
      tdiv_nxt     = ms_tick ? 18'h00000 : tdiv_r + 18'h00001;
      tcnt_nxt     = tcnt_r;
      tick_evt_nxt = 1'b0;
      // The counter has no clock in hibernate, so it freezes there
      if (tick_clr) begin
         tdiv_nxt = 18'h00000;
         tcnt_nxt = 13'h0000;
      end else if (st_r == pmc_pkg::ST_HIB) begin
         tdiv_nxt = tdiv_r;
      end else if (ms_tick) begin
         if (tick_run_r && tcnt_r >= tick_per_r) begin
            tcnt_nxt     = 13'h0000;
            tick_evt_nxt = 1'b1;
         end else begin
            tcnt_nxt = tcnt_r + 13'h0001;
         end
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tdiv_r     <= 18'h00000;
         tcnt_r     <= 13'h0000;
         tick_evt_r <= 1'b0;
      end else begin
         tdiv_r     <= tdiv_nxt;
         tcnt_r     <= tcnt_nxt;
         tick_evt_r <= tick_evt_nxt;
      end
   end

   // ----------------------------------------
   // Boost pulse generator
   // ----------------------------------------
   boost_if bst ();
   logic boost_act_eff;

   // Hibernate cannot keep the boost in standby
   assign boost_act_eff  = boost_r[`BOOST_ACT_BIT] | (st_r == pmc_pkg::ST_HIB);
   assign bst.fsel       = pmc_pkg::boost_fsel_t'(boost_r[1:0]);
   assign bst.enable     = boost_r[`BOOST_EN_BIT];
   assign bst.active     = boost_act_eff;
   assign bst.auto_pulse = boost_r[`BOOST_AUTO_BIT];
   assign bst.below      = lvl_r[2];
   assign bst.xtal_edge  = xtal_edge_r;

   boost_pulse u_boost (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .bst       (bst.gen)
   );

   // ----------------------------------------
   // Registered outputs and read port
   // ----------------------------------------
   logic [`SUBSYS_W-1:0] en_nxt;
   logic [1:0]           mode_nxt;
   logic [31:0]          rdata_nxt;

   always_comb begin
      unique case (st_r)
         pmc_pkg::ST_ACTIVE: begin
            en_nxt   = {act_tmpl_r[`SUBSYS_W-1:1], cpu_on_r};
            mode_nxt = `MODE_ACTIVE;
         end
         pmc_pkg::ST_ALT: begin
            en_nxt   = {alt_tmpl_r[`SUBSYS_W-1:1], alt_tmpl_r[`CPU_BIT] & cpu_on_r};
            mode_nxt = `MODE_ALT;
         end
         pmc_pkg::ST_HIB: begin
            en_nxt   = '0;
            mode_nxt = `MODE_HIB;
         end
         default: begin
            en_nxt   = '0;
            mode_nxt = `MODE_SLEEP;
         end
      endcase
      rdata_nxt = 32'h0000_0000;
      if (rd_in) begin
         unique case (addr_in)
            `REG_MODE:     rdata_nxt = {30'h0, mode_nxt};
            `REG_ACT_TMPL: rdata_nxt = {24'h0, act_tmpl_r};
            `REG_ALT_TMPL: rdata_nxt = {24'h0, alt_tmpl_r};
            `REG_WAKE_EN:  rdata_nxt = {28'h0, wake_en_r};
            `REG_TICK:     rdata_nxt = {18'h0, tick_run_r, tick_per_r};
            `REG_BOOST:    rdata_nxt = {27'h0, boost_r};
            `REG_STATUS:   rdata_nxt = {16'h0, tcnt_r[6:0], cause_r,
                                        st_r == pmc_pkg::ST_RESUME, cpu_on_r, boost_act_eff};
            default:       rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         subsys_clk_en_out     <= '0;
         cpu_en_out            <= 1'b0;
         global_mode_out       <= `MODE_ACTIVE;
         low_speed_clk_sel_out <= 1'b0;
         retain_out            <= 1'b0;
         resuming_out          <= 1'b0;
         tick_irq_out          <= 1'b0;
         boost_switch_out      <= 1'b0;
         boost_active_out      <= 1'b0;
         boost_standby_out     <= 1'b0;
         rdata_out             <= 32'h0000_0000;
      end else begin
         subsys_clk_en_out     <= en_nxt;
         cpu_en_out            <= en_nxt[`CPU_BIT];
         global_mode_out       <= mode_nxt;
         low_speed_clk_sel_out <= (st_r == pmc_pkg::ST_SLEEP);
         retain_out            <= (st_r == pmc_pkg::ST_HIB);
         resuming_out          <= (st_r == pmc_pkg::ST_RESUME);
         tick_irq_out          <= tick_evt_r;
         boost_switch_out      <= bst.pulse;
         boost_active_out      <= boost_r[`BOOST_EN_BIT] & boost_act_eff;
         boost_standby_out     <= boost_r[`BOOST_EN_BIT] & ~boost_act_eff;
         rdata_out             <= rdata_nxt;
      end
   end
endmodule : power_mode_controller
`default_nettype wire

/* File: include/pmc_cfg.svh */
// Constants for the global power mode controller
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
`define CLK_HZ           250000000
`define CLK_PERIOD_NS    4
`define REG_MODE         8'h00
`define REG_ACT_TMPL     8'h04
`define REG_ALT_TMPL     8'h08
`define REG_WAKE_EN      8'h0C
`define REG_TICK         8'h10
`define REG_BOOST        8'h14
`define REG_STATUS       8'h18
`define MODE_ACTIVE      2'h0
`define MODE_ALT         2'h1
`define MODE_SLEEP       2'h2
`define MODE_HIB         2'h3
`define SUBSYS_W         8
`define CPU_BIT          0
`define ACT_TMPL_RST     8'hFF
`define ALT_TMPL_RST     8'hFE
`define WAKE_EN_RST      4'h0
`define WAKE_INT_BIT     0
`define WAKE_LVD_BIT     1
`define WAKE_TICK_BIT    2
`define WAKE_PORT_BIT    3
`define TICK_PER_RST     13'h03E8
`define TICK_RUN_BIT     13
`define TICK_CLR_BIT     14
`define BOOST_RST        5'h00
`define BOOST_ACT_BIT    2
`define BOOST_AUTO_BIT   3
`define BOOST_EN_BIT     4
`define PIN_LVL_RST      3'h1
`define SLEEP_RESUME_NS  15000
`define SLEEP_RESUME_CYC ((`SLEEP_RESUME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HIB_RESUME_NS    100000
`define HIB_RESUME_CYC   ((`HIB_RESUME_NS / `CLK_PERIOD_NS) - 1)
`define TICK_PERIOD_NS   1000000
`define TICK_DIV_CYC     (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define BOOST_DIV_100K   (`CLK_HZ / 100000)
`define BOOST_DIV_400K   (`CLK_HZ / 400000)
`define BOOST_DIV_2M     (`CLK_HZ / 2000000)
`endif

/* File: include/pmc_pkg.sv */
// Types shared by the power mode controller files
`default_nettype none
package pmc_pkg;
   typedef enum logic [2:0] {ST_ACTIVE, ST_ALT, ST_SLEEP, ST_HIB, ST_RESUME} pm_state_t;
   typedef enum logic [1:0] {FSEL_100K, FSEL_400K, FSEL_2M, FSEL_32K} boost_fsel_t;
endpackage : pmc_pkg
`default_nettype wire

/* File: include/boost_if.sv */
// Boost control signals between the controller and the pulse generator
`timescale 1ns/1ns
`default_nettype none
interface boost_if;
   pmc_pkg::boost_fsel_t fsel;
   logic                 enable;
   logic                 active;
   logic                 auto_pulse;
   logic                 below;
   logic                 xtal_edge;
   logic                 pulse;
   modport ctrl (output fsel, enable, active, auto_pulse, below, xtal_edge, input pulse);
   modport gen  (input fsel, enable, active, auto_pulse, below, xtal_edge, output pulse);
endinterface : boost_if
`default_nettype wire

/* File: src/boost_pulse.sv */
// Boost switching clock dividers and inductor pulse generator
`timescale 1ns/1ns
`default_nettype none
`include "pmc_cfg.svh"
module boost_pulse (
   input  wire logic clock_in,
   input  wire logic resetn_in,
   boost_if.gen      bst
);
   localparam int NDIV = 3;

   function automatic logic [11:0] div_of(input int i);
      if (i == 0) begin
         div_of = 12'(`BOOST_DIV_100K);
      end else if (i == 1) begin
         div_of = 12'(`BOOST_DIV_400K);
      end else begin
         div_of = 12'(`BOOST_DIV_2M);
      end
   endfunction : div_of

   logic [NDIV-1:0][11:0] cnt_r;
   logic [NDIV-1:0][11:0] cnt_nxt;
   logic [NDIV-1:0]       rate_tick;
   logic                  sel_tick;
   logic                  pulse_r;
   logic                  pulse_nxt;

   // ----------------------------------------
   // Internal switching oscillators
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NDIV; g++) begin : g_div
         always_comb begin
            rate_tick[g] = (cnt_r[g] == div_of(g) - 12'h001);
            cnt_nxt[g]   = rate_tick[g] ? 12'h000 : cnt_r[g] + 12'h001;
         end
         always_ff @(posedge clock_in or negedge resetn_in) begin
            if (!resetn_in) begin
               cnt_r[g] <= 12'h000;
            end else begin
               cnt_r[g] <= cnt_nxt[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Pulse selection
   // ----------------------------------------
   always_comb begin
      unique case (bst.fsel)
         pmc_pkg::FSEL_100K: sel_tick = rate_tick[0];
         pmc_pkg::FSEL_400K: sel_tick = rate_tick[1];
         pmc_pkg::FSEL_2M:   sel_tick = rate_tick[2];
         pmc_pkg::FSEL_32K:  sel_tick = bst.xtal_edge;
      endcase
      // Standby without auto pulse leaves the switch idle
      if (!bst.enable) begin
         pulse_nxt = 1'b0;
      end else if (bst.active) begin
         pulse_nxt = sel_tick;
      end else begin
         pulse_nxt = bst.auto_pulse & bst.xtal_edge & bst.below;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pulse_r <= 1'b0;
      end else begin
         pulse_r <= pulse_nxt;
      end
   end

   assign bst.pulse = pulse_r;
endmodule : boost_pulse
`default_nettype wire

/* File: tb/pmc_sva.sv */
// Port level assertions for the power mode controller
`timescale 1ns/1ns
`default_nettype none
`include "pmc_cfg.svh"
module pmc_sva #(
   parameter int HIB_RESUME_CYC = `HIB_RESUME_CYC
) (
   input wire logic                 clock_in,
   input wire logic                 resetn_in,
   input wire logic [7:0]           addr_in,
   input wire logic [31:0]          wdata_in,
   input wire logic                 wr_in,
   input wire logic                 rd_in,
   input wire logic [31:0]          rdata_out,
   input wire logic                 irq_internal_in,
   input wire logic                 low_voltage_detect_in,
   input wire logic                 port_interrupt_unit_in,
   input wire logic                 watchdog_reset_event_in,
   input wire logic                 external_reset_pin_n_in,
   input wire logic [`SUBSYS_W-1:0] subsys_clk_en_out,
   input wire logic                 cpu_en_out,
   input wire logic [1:0]           global_mode_out,
   input wire logic                 low_speed_clk_sel_out,
   input wire logic                 retain_out,
   input wire logic                 resuming_out,
   input wire logic                 boost_active_out,
   input wire logic                 boost_standby_out
);
   // Slack covers the synchronisers on both resume paths
   localparam int RESUME_MAX = (HIB_RESUME_CYC > 3750 ? HIB_RESUME_CYC : 3750) + 8;
   logic [15:0] run_r;
   logic [15:0] run_nxt;
   always_comb run_nxt = resuming_out ? run_r + 16'h0001 : 16'h0000;
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) run_r <= 16'h0000;
      else run_r <= run_nxt;
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   chk_cpu_mirror: assert property (cpu_en_out == subsys_clk_en_out[0])
      else $error("processor enable differs from its clock enable");
   chk_sleep_gated: assert property (global_mode_out == 2'h2 && !resuming_out
      |-> subsys_clk_en_out == '0 && low_speed_clk_sel_out) else $error("sleep left clocks on");
   chk_hib_kept: assert property (global_mode_out == 2'h3 && !resuming_out
      |-> retain_out && subsys_clk_en_out == '0) else $error("hibernate not retained");
   chk_mode_write: assert property (wr_in && addr_in == 8'h00 && wdata_in[1:0] == 2'h1
      && global_mode_out == 2'h0 && !resuming_out && external_reset_pin_n_in
      && !(irq_internal_in || low_voltage_detect_in || port_interrupt_unit_in
      || watchdog_reset_event_in) |-> ##[2:3] global_mode_out == 2'h1)
      else $error("mode write not taken");
   chk_wdog_wake: assert property (watchdog_reset_event_in && global_mode_out == 2'h1
      |-> ##[1:6] global_mode_out == 2'h0 && cpu_en_out) else $error("watchdog did not wake");
   chk_hib_hold: assert property ((global_mode_out == 2'h3 && !resuming_out
      && !port_interrupt_unit_in && external_reset_pin_n_in) [*6] |=> global_mode_out == 2'h3)
      else $error("hibernate left without pin interrupt");
   chk_read_idle: assert property (!rd_in || addr_in == 8'h1C |=> rdata_out == 32'h0)
      else $error("read data outside its cycle");
   chk_boost_hib: assert property ($past(global_mode_out) == 2'h3 && global_mode_out == 2'h3
      |-> !boost_standby_out) else $error("boost standby in hibernate");
   chk_boost_excl: assert property (!(boost_active_out && boost_standby_out))
      else $error("boost in both modes");
   chk_resume_bound: assert property (run_r <= RESUME_MAX)
      else $error("resume wait too long");
endmodule : pmc_sva
bind power_mode_controller pmc_sva #(.HIB_RESUME_CYC(HIB_RESUME_CYC)) u_pmc_sva (
   .clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_internal_in(irq_internal_in),
   .low_voltage_detect_in(low_voltage_detect_in), .port_interrupt_unit_in(port_interrupt_unit_in),
   .watchdog_reset_event_in(watchdog_reset_event_in),
   .external_reset_pin_n_in(external_reset_pin_n_in), .subsys_clk_en_out(subsys_clk_en_out),
   .cpu_en_out(cpu_en_out), .global_mode_out(global_mode_out), .retain_out(retain_out),
   .low_speed_clk_sel_out(low_speed_clk_sel_out), .resuming_out(resuming_out),
   .boost_active_out(boost_active_out), .boost_standby_out(boost_standby_out));
`default_nettype wire

/* File: tb/xtal_model.sv */
// Free running crystal clock and boost level comparator
`timescale 1ns/1ns
`default_nettype none
module xtal_model #(
   parameter int HALF = 50
) (
   input  wire logic clock_in,
   output var logic  xtal_out,
   output var logic  below_out
);
   int cnt = 0;
   int flips = 0;
   initial xtal_out = 1'b0;
   initial below_out = 1'b0;
   // Output sags on two edges out of three, so some auto pulses are skipped
   always @(posedge clock_in) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
         xtal_out <= ~xtal_out;
         flips <= flips + 1;
         below_out <= (flips % 3) != 0;
      end
   end
endmodule : xtal_model
`default_nettype wire

/* File: tb/power_mode_controller_test.sv */
// Self-checking bench for the power mode controller
`timescale 1ns/1ns
`default_nettype none
`include "pmc_cfg.svh"
module power_mode_controller_test;
   localparam int XH = 50;
   localparam int HC = 20;
   logic        clock_in, resetn_in, wr_in, rd_in, ext_n, xtal, below;
   logic        cpu, lsc, ret, resm, tick, sw, bact, bsby;
   logic [1:0]  mode;
   logic [4:0]  src;
   logic [7:0]  addr_in, en, d, act;
   logic [31:0] wdata_in, rdata_out;
   int          bad_count, checked, n, k;
   power_mode_controller #(.HIB_RESUME_CYC(HC), .TICK_DIV_CYC(10)) dut (
      .clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cpu_off_req_in(src[4]),
      .irq_internal_in(src[0]), .low_voltage_detect_in(src[1]),
      .port_interrupt_unit_in(src[2]), .watchdog_reset_event_in(src[3]),
      .external_reset_pin_n_in(ext_n), .khz_crystal_osc_in(xtal), .boost_below_level_in(below),
      .subsys_clk_en_out(en), .cpu_en_out(cpu), .global_mode_out(mode),
      .low_speed_clk_sel_out(lsc), .retain_out(ret), .resuming_out(resm), .tick_irq_out(tick),
      .boost_switch_out(sw), .boost_active_out(bact), .boost_standby_out(bsby));
   xtal_model #(.HALF(XH)) u_xtal (.clock_in(clock_in), .xtal_out(xtal), .below_out(below));
   function automatic int exp_p(input int f);
      if (f == 3) return 3000 / XH;
      return 3000 / (f == 0 ? `BOOST_DIV_100K : f == 1 ? `BOOST_DIV_400K : `BOOST_DIV_2M);
   endfunction : exp_p
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task stop_test();
      if (bad_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= v;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clock_in);
      rd_in <= 1'b0;
      @(negedge clock_in);
      check(rdata_out, exp);
   endtask : rd
   task cyc(input int k);
      repeat (k) @(posedge clock_in);
      @(negedge clock_in);
   endtask : cyc
   task pulse(input int i);
      @(posedge clock_in);
      src[i] <= 1'b1;
      @(posedge clock_in);
      src <= 5'h00;
   endtask : pulse
   task wait_act();
      n = 0;
      while (mode !== 2'h0 && n < 8000) begin
         @(negedge clock_in);
         n++;
      end
   endtask : wait_act
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
   initial begin
      {resetn_in, wr_in, rd_in, src, addr_in, wdata_in} = '0;
      ext_n = 1'b1;
      n = $urandom(5899);
      repeat (4) @(posedge clock_in);
      resetn_in <= 1'b1;
      cyc(1);
      check(mode, `MODE_ACTIVE);
      check(en, 8'hFF);
      rd(`REG_ACT_TMPL, 32'h000000FF);
      rd(`REG_ALT_TMPL, 32'h000000FE);
      rd(8'h1C, 32'h0);
      repeat (4) begin
         act = 8'($urandom);
         wr(`REG_ACT_TMPL, {24'h0, act});
         cyc(2);
         check(en, act);
      end
      d = 8'($urandom) & 8'hFE;
      wr(`REG_ALT_TMPL, {24'h0, d});
      wr(`REG_MODE, 32'h1);
      cyc(3);
      check(mode, `MODE_ALT);
      check(en, d);
      pulse(3);
      cyc(4);
      check({mode, cpu}, {`MODE_ACTIVE, 1'b1});
      wr(`REG_WAKE_EN, 32'hF);
      pulse(4);
      cyc(3);
      check(cpu, 1'b0);
      pulse(0);
      cyc(4);
      check(cpu, 1'b1);
      wr(`REG_BOOST, 32'h1B);
      wr(`REG_MODE, 32'h2);
      cyc(3);
      check({mode, en, lsc}, {`MODE_SLEEP, 8'h00, 1'b1});
      wr(`REG_MODE, 32'h1);
      cyc(3);
      check(mode, `MODE_SLEEP);
      pulse(1);
      wait_act();
      check(n >= 3748 && n <= 3760, 1'b1);
      wr(`REG_MODE, 32'h2);
      cyc(3);
      @(posedge clock_in);
      ext_n <= 1'b0;
      cyc(8);
      check(mode, `MODE_ACTIVE);
      @(posedge clock_in);
      ext_n <= 1'b1;
      cyc(6);
      wr(`REG_ACT_TMPL, {24'h0, act});
      wr(`REG_MODE, 32'h2);
      wr(`REG_TICK, 32'h2002);
      wr(`REG_WAKE_EN, 32'h4);
      cyc(2);
      wait_act();
      check(n > 3700 && n < 6000, 1'b1);
      for (int f = 0; f < 4; f++) begin
         wr(`REG_BOOST, 32'h14 | 32'(f));
         cyc(2);
         n = 0;
         k = 0;
         repeat (3000) begin
            @(negedge clock_in);
            if (sw === 1'b1) n++;
            if (tick === 1'b1) k++;
         end
         check(n >= exp_p(f) - 1 && n <= exp_p(f) + 1, 1'b1);
         check(k, 100);
      end
      wr(`REG_TICK, 32'h4002);
      check({bact, bsby}, 2'b10);
      wr(`REG_BOOST, 32'h1B);
      cyc(2);
      n = 0;
      repeat (1000) begin
         @(negedge clock_in);
         if (sw === 1'b1) n++;
      end
      check({bsby, 1'(n >= 10 && n <= 20)}, 2'b11);
      wr(`REG_WAKE_EN, 32'hF);
      wr(`REG_MODE, 32'h3);
      cyc(3);
      check({ret, bact}, 2'b11);
      for (int i = 0; i < 4; i++) if (i != 2) pulse(i);
      cyc(8);
      check(mode, `MODE_HIB);
      pulse(2);
      wait_act();
      check(n >= HC - 2 && n <= HC + 10, 1'b1);
      cyc(2);
      check(en, act | 8'h01);
      stop_test();
   end
endmodule : power_mode_controller_test
`default_nettype wire
